// [hw/cog_pkg.sv]
// Package with register map, field positions, reset values and timing for output gating control
package cog_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] COG_REG_CTRL = 8'h88;
  localparam logic [7:0] COG_REG_MON_HIGH = 8'h8A;
  localparam logic [7:0] COG_REG_MON_LOW = 8'h8B;
  localparam logic [7:0] COG_REG_NVM_REV = 8'hB9;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int COG_CTRL_SOFT_RESET_BIT = 7;
  localparam int COG_CTRL_CAL_START_BIT = 6;
  localparam int COG_MON_HIGH_BIT = 0;
  localparam int COG_MON_LOW_BIT = 4;
  // ----------------------------------------------------------------
  // Reset values and unmapped read value
  // ----------------------------------------------------------------
  localparam logic [7:0] COG_MON_HIGH_RESET = 8'h0F;
  localparam logic [7:0] COG_MON_LOW_RESET = 8'hFF;
  localparam logic [7:0] COG_UNMAPPED_READ = 8'h00;
  // ----------------------------------------------------------------
  // Monitor select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] COG_MON_OFF = 2'h0;
  localparam logic [1:0] COG_MON_RESERVED = 2'h1;
  localparam logic [1:0] COG_MON_SLOW = 2'h2;
  localparam logic [1:0] COG_MON_NORMAL = 2'h3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int COG_CLK_KHZ = 40000;
  localparam int COG_CAL_TIMEOUT_US = 1000;
  localparam int COG_CAL_TIMEOUT_CYC = COG_CAL_TIMEOUT_US * COG_CLK_KHZ / 1000;
endpackage

// [hw/cog_output_ctrl.sv]
// Output gating, calibration tracking, monitor select, reset and alarm pin control
module cog_output_ctrl
  import cog_pkg::*;
#(
  parameter int NUM_EVENTS = 4,
  parameter int CAL_TIMEOUT_CYC = COG_CAL_TIMEOUT_CYC,
  parameter logic [7:0] NVM_REVISION = 8'h5A, // Arbitrary value
  parameter logic [1:0] SPEED_GRADE = 2'h0 // Arbitrary value
)
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  output logic [7:0] REG_RDATA,
  input wire logic OUTPUT_KEEP_RUNNING,
  input wire logic SQUELCH_UNTIL_CALIBRATED,
  input wire logic IRQ_PIN_ENABLE,
  input wire logic IRQ_PIN_POLARITY,
  input wire logic INPUT_ALARM_PIN_ENABLE,
  input wire logic INPUT_ALARM_POLARITY,
  input wire logic INPUT_SIGNAL_ABSENT,
  input wire logic PLL_UNLOCK_INDICATION,
  input wire logic [NUM_EVENTS-1:0] EVENT_SET,
  input wire logic [NUM_EVENTS-1:0] EVENT_CLEAR,
  input wire logic [NUM_EVENTS-1:0] EVENT_MASK,
  output logic SYNTHESIZED_OUTPUT_EN,
  output logic CAL_START,
  output logic CAL_BUSY,
  output logic SLOW_ABSENCE_MONITOR_EN,
  output logic NORMAL_ABSENCE_MONITOR_EN,
  output logic SHARED_ALARM_PIN_O,
  output logic SHARED_ALARM_PIN_OE
);
  localparam int CW = $clog2(CAL_TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_TIMEOUT_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic soft_reset;
    logic mon_high;
    logic mon_low;
    logic cal_active;
    logic [CW-1:0] cal_cnt;
    logic cal_done;
    logic cal_good;
    logic [NUM_EVENTS-1:0] flags;
    logic out_en;
    logic cal_start;
    logic slow_en;
    logic norm_en;
    logic pin_o;
    logic pin_oe;
    logic [7:0] rdata;
  } cog_state_t;

  localparam cog_state_t COG_STATE_RESET = '{
    soft_reset: 1'b0,
    mon_high: COG_MON_HIGH_RESET[COG_MON_HIGH_BIT],
    mon_low: COG_MON_LOW_RESET[COG_MON_LOW_BIT],
    cal_active: 1'b0,
    cal_cnt: '0,
    cal_done: 1'b0,
    cal_good: 1'b0,
    flags: '0,
    out_en: 1'b0,
    cal_start: 1'b0,
    slow_en: 1'b0,
    norm_en: 1'b0,
    pin_o: 1'b0,
    pin_oe: 1'b0,
    rdata: 8'h00
  };

  cog_state_t s;
  cog_state_t next_s;

  function automatic logic cog_wr(input logic [7:0] addr, input logic [7:0] a, input logic we);
    cog_wr = we && (addr == a);
  endfunction

  logic int_reset;
  logic [1:0] mon_code;
  logic any_irq;
  logic start_req;

  assign int_reset = !RST_N || s.soft_reset;
  assign mon_code = {s.mon_high, s.mon_low};
  assign any_irq = |(s.flags & EVENT_MASK);
  assign start_req = cog_wr(REG_ADDR, COG_REG_CTRL, REG_WE) && REG_WDATA[COG_CTRL_CAL_START_BIT];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.cal_start = 1'b0;
    // Register writes
    if (cog_wr(REG_ADDR, COG_REG_MON_HIGH, REG_WE))
    begin
      next_s.mon_high = REG_WDATA[COG_MON_HIGH_BIT];
    end
    if (cog_wr(REG_ADDR, COG_REG_MON_LOW, REG_WE))
    begin
      next_s.mon_low = REG_WDATA[COG_MON_LOW_BIT];
    end
    if (cog_wr(REG_ADDR, COG_REG_CTRL, REG_WE))
    begin
      next_s.soft_reset = REG_WDATA[COG_CTRL_SOFT_RESET_BIT];
    end
    // Calibration: start pulse, end on lock or on timeout
    if (start_req)
    begin
      next_s.cal_start = 1'b1;
      next_s.cal_active = 1'b1;
      next_s.cal_cnt = '0;
    end
    else if (s.cal_active)
    begin
      // Lock (no unlock) is not trusted in the start cycle, before the loop has reacted
      if (!PLL_UNLOCK_INDICATION && !s.cal_start)
      begin
        next_s.cal_active = 1'b0;
        next_s.cal_done = 1'b1;
        next_s.cal_good = 1'b1;
      end
      else if (s.cal_cnt == CAL_LAST)
      begin
        next_s.cal_active = 1'b0;
        next_s.cal_done = 1'b1;
      end
      else
      begin
        next_s.cal_cnt = s.cal_cnt + CW'(1);
      end
    end
    // Event flags: set wins over clear
    next_s.flags = (s.flags & ~EVENT_CLEAR) | EVENT_SET;
    // Output gating
    if (OUTPUT_KEEP_RUNNING)
    begin
      next_s.out_en = 1'b1;
    end
    else if (SQUELCH_UNTIL_CALIBRATED)
    begin
      next_s.out_en = s.cal_good;
    end
    else
    begin
      next_s.out_en = s.cal_done;
    end
    // Monitor select decode, reserved code disables both
    next_s.slow_en = (mon_code == COG_MON_SLOW);
    next_s.norm_en = (mon_code == COG_MON_NORMAL);
    // Shared alarm pin
    if (IRQ_PIN_ENABLE)
    begin
      next_s.pin_oe = 1'b1;
      next_s.pin_o = ~(any_irq ^ IRQ_PIN_POLARITY);
    end
    else if (INPUT_ALARM_PIN_ENABLE)
    begin
      next_s.pin_oe = 1'b1;
      next_s.pin_o = ~(INPUT_SIGNAL_ABSENT ^ INPUT_ALARM_POLARITY);
    end
    else
    begin
      next_s.pin_oe = 1'b0;
      next_s.pin_o = 1'b0;
    end
    // Register reads
    next_s.rdata = s.rdata;
    if (REG_RE)
    begin
      unique case (REG_ADDR)
        COG_REG_CTRL: next_s.rdata = {6'h00, SPEED_GRADE};
        COG_REG_MON_HIGH: next_s.rdata = {COG_MON_HIGH_RESET[7:1], s.mon_high};
        COG_REG_MON_LOW: next_s.rdata = {COG_MON_LOW_RESET[7:5], s.mon_low,
                                         COG_MON_LOW_RESET[3:0]};
        COG_REG_NVM_REV: next_s.rdata = NVM_REVISION;
        default: next_s.rdata = COG_UNMAPPED_READ;
      endcase
    end
    // Pin or register reset restores defaults, outputs off
    if (int_reset)
    begin
      next_s = COG_STATE_RESET;
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      s <= COG_STATE_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA = s.rdata;
  assign SYNTHESIZED_OUTPUT_EN = s.out_en;
  assign CAL_START = s.cal_start;
  assign CAL_BUSY = s.cal_active;
  assign SLOW_ABSENCE_MONITOR_EN = s.slow_en;
  assign NORMAL_ABSENCE_MONITOR_EN = s.norm_en;
  assign SHARED_ALARM_PIN_O = s.pin_o;
  assign SHARED_ALARM_PIN_OE = s.pin_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cog_cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  sequence cog_cal_req;
    start_req && !int_reset;
  endsequence

  sequence cog_cal_pulse;
    CAL_START && CAL_BUSY ##1 (!CAL_START || $past(start_req));
  endsequence

  sequence cog_cal_expire;
    CAL_BUSY && !CAL_START && PLL_UNLOCK_INDICATION && (s.cal_cnt == CAL_LAST) && !start_req
      && !int_reset;
  endsequence

  chk_monitor_normal: assert property (
    (mon_code == COG_MON_NORMAL) && !int_reset |=> NORMAL_ABSENCE_MONITOR_EN
      && !SLOW_ABSENCE_MONITOR_EN)
    else $error("normal monitor not selected");
  chk_monitor_slow: assert property (
    (mon_code == COG_MON_SLOW) && !int_reset |=> SLOW_ABSENCE_MONITOR_EN
      && !NORMAL_ABSENCE_MONITOR_EN)
    else $error("slow monitor not selected");
  chk_monitor_split: assert property (
    cog_wr(REG_ADDR, COG_REG_MON_LOW, REG_WE) && !int_reset
      |=> s.mon_low == $past(REG_WDATA[COG_MON_LOW_BIT]))
    else $error("low monitor bit not stored");
  chk_squelch_first: assert property (
    !OUTPUT_KEEP_RUNNING && !SQUELCH_UNTIL_CALIBRATED && !s.cal_done
      |=> !SYNTHESIZED_OUTPUT_EN)
    else $error("output on before first calibration");
  chk_squelch_good: assert property (
    !OUTPUT_KEEP_RUNNING && SQUELCH_UNTIL_CALIBRATED && !s.cal_good
      |=> !SYNTHESIZED_OUTPUT_EN)
    else $error("output on before good calibration");
  chk_keep_running: assert property (
    OUTPUT_KEEP_RUNNING && !int_reset |=> SYNTHESIZED_OUTPUT_EN)
    else $error("keep-running output stopped");
  chk_cal_selfclear: assert property (
    cog_cal_req |=> cog_cal_pulse)
    else $error("calibration start did not pulse once");
  chk_cal_complete: assert property (
    CAL_BUSY && !CAL_START && !PLL_UNLOCK_INDICATION && !start_req && !int_reset
      |=> !CAL_BUSY && s.cal_good)
    else $error("calibration did not end on lock");
  chk_reset_outputs: assert property (
    !RST_N |=> !SYNTHESIZED_OUTPUT_EN && !SHARED_ALARM_PIN_OE && !CAL_BUSY)
    else $error("outputs active during reset");
  chk_irq_level: assert property (
    IRQ_PIN_ENABLE && !int_reset |=> SHARED_ALARM_PIN_OE
      && (SHARED_ALARM_PIN_O == !($past(any_irq) ^ $past(IRQ_PIN_POLARITY))))
    else $error("interrupt pin level wrong");
  chk_alarm_level: assert property (
    !IRQ_PIN_ENABLE && INPUT_ALARM_PIN_ENABLE && !int_reset |=> SHARED_ALARM_PIN_OE
      && (SHARED_ALARM_PIN_O == !($past(INPUT_SIGNAL_ABSENT) ^ $past(INPUT_ALARM_POLARITY))))
    else $error("alarm pin level wrong");
  chk_pin_tristate: assert property (
    !IRQ_PIN_ENABLE && !INPUT_ALARM_PIN_ENABLE |=> !SHARED_ALARM_PIN_OE)
    else $error("pin driven with no function");
  chk_monitor_off: assert property (
    (mon_code == COG_MON_OFF || mon_code == COG_MON_RESERVED) && !int_reset
      |=> !SLOW_ABSENCE_MONITOR_EN && !NORMAL_ABSENCE_MONITOR_EN)
    else $error("monitor enabled for off or reserved code");
  chk_cal_timeout: assert property (
    cog_cal_expire |=> !CAL_BUSY && s.cal_done)
    else $error("failed calibration did not end");
  chk_flag_set_wins: assert property (
    (|EVENT_SET) && !int_reset
      |=> (s.flags & $past(EVENT_SET)) == $past(EVENT_SET))
    else $error("event flag not latched");
  chk_soft_reset_clear: assert property (
    s.soft_reset |=> !s.soft_reset && !SYNTHESIZED_OUTPUT_EN && !SHARED_ALARM_PIN_OE)
    else $error("register reset did not restore defaults");
endmodule

// [testbench/cog_host_model.sv]
// Host controller model: drives the reset pin and watches the shared alarm pin
module cog_host_model (
  input wire logic MCLK,
  input wire logic HOLD_RESET,
  input wire logic PIN_O,
  input wire logic PIN_OE,
  output logic RST_N,
  output logic PIN_LEVEL
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_level;
  // Reset pin follows the host's request one edge later
  always_ff @(posedge MCLK)
  begin
    RST_N <= ~HOLD_RESET;
    if (PIN_OE)
    begin
      last_level <= PIN_O;
    end
  end
  // Released pin shows the inverse of the level last driven
  assign PIN_LEVEL = PIN_OE ? PIN_O : ~last_level;
endmodule

// [testbench/test_clock_output_gating_alarm_ctrl.sv]
// Self-checking testbench of the output gating and alarm pin control
module test_clock_output_gating_alarm_ctrl
  import cog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] NVM_REV = 8'h3C; // Arbitrary value
  logic clk, reset, hold, rst_n, we, re, keep, sq, irq_en, irq_pol;
  logic alm_en, alm_pol, absent, unlock, out_en, cal_start, cal_busy;
  logic slow_en, norm_en, pin_o, pin_oe, pin;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] evs, evc, evm;
  int failures = 0;
  int total_checks = 0;
  cog_output_ctrl #(.CAL_TIMEOUT_CYC(8), .NVM_REVISION(NVM_REV)) dut (
    .MCLK(clk), .RESET(reset), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .OUTPUT_KEEP_RUNNING(keep),
    .SQUELCH_UNTIL_CALIBRATED(sq), .IRQ_PIN_ENABLE(irq_en), .IRQ_PIN_POLARITY(irq_pol),
    .INPUT_ALARM_PIN_ENABLE(alm_en), .INPUT_ALARM_POLARITY(alm_pol),
    .INPUT_SIGNAL_ABSENT(absent), .PLL_UNLOCK_INDICATION(unlock), .EVENT_SET(evs),
    .EVENT_CLEAR(evc), .EVENT_MASK(evm), .SYNTHESIZED_OUTPUT_EN(out_en),
    .CAL_START(cal_start), .CAL_BUSY(cal_busy), .SLOW_ABSENCE_MONITOR_EN(slow_en),
    .NORMAL_ABSENCE_MONITOR_EN(norm_en), .SHARED_ALARM_PIN_O(pin_o),
    .SHARED_ALARM_PIN_OE(pin_oe));
  cog_host_model host (.MCLK(clk), .HOLD_RESET(hold), .PIN_O(pin_o), .PIN_OE(pin_oe),
    .RST_N(rst_n), .PIN_LEVEL(pin));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(rdata, exp, "read data");
  endtask
  task automatic ev_pulse(input bit set);
    @(posedge clk);
    if (set)
    begin
      evs <= 4'h1;
    end
    else
    begin
      evc <= 4'h1;
    end
    @(posedge clk);
    evs <= 4'h0;
    evc <= 4'h0;
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #(4000 * 25);
    failures++;
    end_of_test();
  end
  initial
  begin
    {reset, hold, we, re, keep, sq, irq_en, irq_pol} = 8'hC0;
    {alm_en, alm_pol, absent, unlock} = 4'h0;
    {addr, wdata, evs, evc, evm} = '0;
    repeat (6) @(posedge clk);
    {reset, hold} <= 2'h0;
    cyc(2);
    rd(COG_REG_MON_LOW, 8'hFF);
    rd(COG_REG_MON_HIGH, 8'h0F);
    rd(COG_REG_NVM_REV, NVM_REV);
    rd(8'h10, 8'h00);
    for (int c = 3; c >= 0; c--)
    begin
      wr(COG_REG_MON_HIGH, {7'h00, c[1]});
      wr(COG_REG_MON_LOW, {3'h7, c[0], 4'hF});
      cyc(2);
      chk({slow_en, norm_en}, (c == 2) ? 8'h2 : (c == 3) ? 8'h1 : 8'h0, "monitor");
    end
    $display("Monitor select test done");
    chk(out_en, 8'h0, "gate before cal");
    keep <= 1'b1;
    cyc(2);
    chk(out_en, 8'h1, "keep running");
    keep <= 1'b0;
    unlock <= 1'b1;
    wr(COG_REG_CTRL, 8'h40);
    chk({cal_start, cal_busy}, 8'h3, "cal start");
    cyc(1);
    chk({cal_start, cal_busy}, 8'h1, "cal self clear");
    sq <= 1'b1;
    cyc(14);
    chk({cal_busy, out_en}, 8'h0, "failed cal squelched");
    sq <= 1'b0;
    cyc(2);
    chk(out_en, 8'h1, "after first cal");
    rd(COG_REG_MON_LOW, 8'hEF);
    hold <= 1'b1;
    cyc(3);
    chk(out_en, 8'h0, "output off in reset");
    hold <= 1'b0;
    cyc(2);
    rd(COG_REG_MON_LOW, 8'hFF);
    sq <= 1'b1;
    wr(COG_REG_CTRL, 8'h40);
    cyc(3);
    chk(out_en, 8'h0, "squelch while unlocked");
    unlock <= 1'b0;
    cyc(4);
    chk({cal_busy, out_en}, 8'h1, "good cal");
    reset <= 1'b1;
    cyc(1);
    reset <= 1'b0;
    {keep, unlock} <= 2'h3;
    wr(COG_REG_CTRL, 8'h40);
    cyc(2);
    chk({cal_busy, out_en}, 8'h3, "runs through cal");
    $display("Gating test done");
    for (int p = 0; p < 2; p++)
    begin
      {irq_en, irq_pol, evm} <= {1'b1, p[0], 4'h0};
      ev_pulse(1'b1);
      cyc(2);
      chk({pin_oe, pin}, {7'h01, ~p[0]}, "masked flag");
      evm <= 4'h1;
      cyc(2);
      chk({pin_oe, pin}, {7'h01, p[0]}, "irq asserted");
      ev_pulse(1'b0);
      cyc(2);
      chk({pin_oe, pin}, {7'h01, ~p[0]}, "irq cleared");
    end
    {irq_en, alm_en} <= 2'h1;
    for (int k = 0; k < 4; k++)
    begin
      {alm_pol, absent} <= k[1:0];
      cyc(2);
      chk({pin_oe, pin}, {7'h01, k[1] ? k[0] : !k[0]}, "alarm level");
    end
    alm_en <= 1'b0;
    cyc(2);
    chk({pin_oe, pin}, 8'h00, "pin released");
    $display("Alarm pin test done");
    wr(COG_REG_MON_LOW, 8'h00);
    wr(COG_REG_CTRL, 8'h80);
    cyc(1);
    chk(out_en, 8'h0, "output off in register reset");
    rd(COG_REG_MON_LOW, 8'hFF);
    rd(COG_REG_CTRL, 8'h00);
    $display("Register reset test done");
    end_of_test();
  end
endmodule
